// file: core/cuesup_map.vh
`ifndef CUESUP_MAP_VH
`define CUESUP_MAP_VH
// Status word error codes
`define CUESUP_CODE_NONE      8'h00
`define CUESUP_CODE_SETTING   8'h02
`define CUESUP_CODE_ALLOC     8'h15
`define CUESUP_CODE_WDT       8'h0e
`define CUESUP_CODE_HOSTCOMM  8'h0c
`define CUESUP_CODE_HOSTRUN   8'h0d
// Status word field layout
`define CUESUP_STAT_CODE_LSB  0
`define CUESUP_STAT_FATAL_BIT 8
`define CUESUP_STAT_NONF_BIT  9
`define CUESUP_STAT_WDT_BIT   10
// Timing, clock 10 MHz
`define CUESUP_CLK_HZ         10000000
`define CUESUP_STEP_MS        500
`define CUESUP_MAX_MS         5000
`define CUESUP_HOST_WAIT_S    120
`define CUESUP_FLASH_MS       250
`define CUESUP_STEP_CYC       ((`CUESUP_CLK_HZ / 1000) * `CUESUP_STEP_MS)
`define CUESUP_FLASH_CYC      ((`CUESUP_CLK_HZ / 1000) * `CUESUP_FLASH_MS)
`define CUESUP_MAX_STEPS      (`CUESUP_MAX_MS / `CUESUP_STEP_MS)
`define CUESUP_HOST_STEPS     ((`CUESUP_HOST_WAIT_S * 1000) / `CUESUP_STEP_MS)
`define CUESUP_WRITE_RETRIES  2
// Reset values
`define CUESUP_RST_TMO        4'h0
`define CUESUP_RST_ADDR       16'h0000
`endif

// file: core/cuesup_top.v
`timescale 1ns/100ps
// Contract
// RQ1: Command bits and variable-type areas are used live each scan, no restart needed.
// RQ2: Setting errors are non-fatal, cleared only by stop-to-run.
// RQ3: Allocation overrun is fatal and latched; cleared by power or stop-to-run.
// RQ4: Component response timeout set in 500 ms steps, at most 5.0 s.
// RQ5: Timeout setting 0 gives the default 500 ms.
// RQ6: Fatal error lights lamp steady; non-fatal error flashes it.
// RQ7: No host contact at start-up is fatal, cleared only by power.
// RQ8: Host link fault after start-up is fatal, cleared only by power.
// RQ9: Write blocked by host run mode is fatal, cleared only by power.
// RQ10: Watchdog timeout is fatal, shown in status word, latched until power.
// RQ11: Allocation overrun writes code 15 to the status word.
// RQ12: Component fault is non-fatal and clears itself when the fault ends.
// RQ13: Bad setting writes code 02 and the bad word address.
// RQ14: Component fault details go to the matching response monitor area.
// RQ15: Host program clears write request after writing, to spare nonvolatile wear.
// RQ16: Host program selects volatile or backup mode during one scan only.
// RQ17: Configuration words take effect only on stop-to-run.
// RQ18: Keep retrying host contact; fatal after 2 minutes without answer.
// RQ19: Retry mode change and rewrite twice before declaring fatal.
// RQ20: Lamp off with no error; fatal outranks non-fatal.
`include "cuesup_map.vh"
module cuesup_top (
    input  wire        clk_sys,        // 10 MHz system clock
    input  wire        rst,            // Power-up reset, sync, active high
    input  wire        scan_tick,      // One pulse per scan cycle
    input  wire        run_ctl,        // Run control digit, 1 = run
    input  wire [3:0]  cfg_timeout,    // Timeout setting, 500 ms steps
    input  wire [15:0] cmd_bits,       // Read/write command bits, live
    input  wire        host_ack,       // Host answered a contact attempt
    input  wire        host_comm_err,  // Host link fault pulse
    input  wire        write_fail,     // Host write refused, host in run
    input  wire        wdt_expired,    // Internal watchdog timeout pulse
    input  wire        alloc_overrun,  // Memory allocation beyond boundary
    input  wire        setting_err,    // Invalid setting found
    input  wire [15:0] setting_addr,   // Word address of invalid setting
    input  wire        comp_req,       // Component request sent
    input  wire        comp_resp,      // Component answer received
    input  wire        comp_err,       // Component frame error pulse
    input  wire [4:0]  comp_index,     // Component being polled
    input  wire [7:0]  comp_err_code,  // Detail code of component fault
    output reg  [15:0] status_word,    // Unit status word
    output reg  [15:0] bad_setting_address_word, // Offending setting address
    output reg  [15:0] active_cmd_bits,  // Command bits in use this scan
    output reg  [3:0]  active_timeout,   // Timeout latched at stop-to-run
    output reg         retry_write,      // Request a mode change and rewrite
    output reg         mon_we,           // Response monitor write strobe
    output reg  [4:0]  mon_index,        // Response monitor component index
    output reg  [7:0]  mon_code,         // Response monitor detail code
    output reg         host_ready,       // Host contact established
    output reg         comp_fault,       // Component fault active
    output wire        fatal_err,        // Fatal class active
    output wire        nonfatal_err,     // Non-fatal class active
    output wire        err_lamp          // Error lamp drive
);
    // ****************************************
    // Registers
    // ****************************************
    reg        run_d_reg;
    reg        wdt_reg, alloc_reg, host_fail_reg, hostrun_reg, setting_reg;
    reg [1:0]  retry_cnt_reg;
    reg [22:0] step_cnt_reg;
    reg [7:0]  host_steps_reg;
    reg [3:0]  comp_steps_reg;
    reg        comp_wait_reg;
    reg [21:0] flash_cnt_reg;
    reg        flash_reg;

    wire run_rise = run_ctl & ~run_d_reg;
    wire step_tick = (step_cnt_reg == `CUESUP_STEP_CYC - 1);

    // Timeout in steps; setting 0 and 1 both mean one step
    function [3:0] tmo_steps;
        input [3:0] set;
        reg   [31:0] cap;
        begin
            cap = `CUESUP_MAX_STEPS;
            if (set == 4'h0)
                tmo_steps = 4'h1;
            else if (set > cap)
                tmo_steps = cap[3:0];
            else
                tmo_steps = set;
        end
    endfunction

    // Watch expiry; a new request restarts the watch instead
    wire comp_tmo = !comp_req && comp_wait_reg && step_tick &&
                    (comp_steps_reg == tmo_steps(active_timeout) - 4'h1);

    assign fatal_err    = wdt_reg | alloc_reg | host_fail_reg | hostrun_reg;
    assign nonfatal_err = setting_reg | comp_fault;
    // RQ6 RQ20 lamp class priority
    assign err_lamp = fatal_err ? 1'b1 : (nonfatal_err ? flash_reg : 1'b0);

    // ****************************************
    // Step and flash timers
    // ****************************************
    always @(posedge clk_sys) begin
        if (rst) begin
            step_cnt_reg  <= 23'h0;
            flash_cnt_reg <= 22'h0;
            flash_reg     <= 1'b0;
            run_d_reg     <= 1'b0;
        end else begin
            run_d_reg <= run_ctl;
            step_cnt_reg <= step_tick ? 23'h0 : step_cnt_reg + 23'h1;
            if (flash_cnt_reg == `CUESUP_FLASH_CYC - 1) begin
                flash_cnt_reg <= 22'h0;
                flash_reg     <= ~flash_reg;
            end else begin
                flash_cnt_reg <= flash_cnt_reg + 22'h1;
            end
        end
    end

    // ****************************************
    // Configuration and live command bits
    // ****************************************
    always @(posedge clk_sys) begin
        if (rst) begin
            active_timeout  <= `CUESUP_RST_TMO;
            active_cmd_bits <= 16'h0000;
        end else begin
            // RQ17 latch on stop-to-run
            if (run_rise)
                active_timeout <= cfg_timeout;
            // RQ1 re-read each scan
            if (scan_tick)
                active_cmd_bits <= run_ctl ? cmd_bits : 16'h0000;
        end
    end

    // ****************************************
    // Host contact and fatal latches
    // ****************************************
    always @(posedge clk_sys) begin
        if (rst) begin
            host_ready     <= 1'b0;
            host_steps_reg <= 8'h0;
            host_fail_reg  <= 1'b0;
            hostrun_reg    <= 1'b0;
            wdt_reg        <= 1'b0;
            alloc_reg      <= 1'b0;
            retry_cnt_reg  <= 2'h0;
            retry_write    <= 1'b0;
        end else begin
            retry_write <= 1'b0;
            // RQ18 give up after two minutes
            if (!host_ready && !host_fail_reg) begin
                if (host_ack)
                    host_ready <= 1'b1;
                else if (step_tick) begin
                    if (host_steps_reg == `CUESUP_HOST_STEPS - 1)
                        // RQ7 no contact is fatal
                        host_fail_reg <= 1'b1;
                    else
                        host_steps_reg <= host_steps_reg + 8'h1;
                end
            end
            // RQ8 link fault after start
            if (host_ready && host_comm_err)
                host_fail_reg <= 1'b1;
            // RQ19 two retries first
            if (write_fail && !hostrun_reg) begin
                if (retry_cnt_reg == `CUESUP_WRITE_RETRIES)
                    // RQ9 blocked write fatal
                    hostrun_reg <= 1'b1;
                else begin
                    retry_cnt_reg <= retry_cnt_reg + 2'h1;
                    retry_write   <= 1'b1;
                end
            end
            // RQ10 watchdog latched
            if (wdt_expired)
                wdt_reg <= 1'b1;
            // RQ3 overrun held; set wins over restart clear
            if (alloc_overrun)
                alloc_reg <= 1'b1;
            else if (run_rise)
                alloc_reg <= 1'b0;
        end
    end

    // ****************************************
    // Non-fatal errors
    // ****************************************
    always @(posedge clk_sys) begin
        if (rst) begin
            setting_reg              <= 1'b0;
            bad_setting_address_word <= `CUESUP_RST_ADDR;
            comp_fault               <= 1'b0;
            comp_wait_reg            <= 1'b0;
            comp_steps_reg           <= 4'h0;
            mon_we                   <= 1'b0;
            mon_index                <= 5'h0;
            mon_code                 <= 8'h00;
        end else begin
            mon_we <= 1'b0;
            // RQ2 RQ13 held until restart
            if (setting_err) begin
                setting_reg              <= 1'b1;
                bad_setting_address_word <= setting_addr;
            end else if (run_rise)
                setting_reg <= 1'b0;
            // RQ4 RQ5 response watch
            if (comp_req) begin
                comp_wait_reg  <= 1'b1;
                comp_steps_reg <= 4'h0;
            end else if (comp_tmo) begin
                comp_wait_reg <= 1'b0;
                comp_fault    <= 1'b1;
                mon_we        <= 1'b1;
                mon_index     <= comp_index;
                mon_code      <= 8'hff;
            end else if (comp_wait_reg && step_tick) begin
                comp_steps_reg <= comp_steps_reg + 4'h1;
            end
            // RQ12 RQ14 fault self-clears; a same-cycle timeout wins
            if (comp_err) begin
                comp_fault <= 1'b1;
                mon_we     <= 1'b1;
                mon_index  <= comp_index;
                mon_code   <= comp_err_code;
            end else if (comp_resp && !comp_tmo) begin
                comp_wait_reg <= 1'b0;
                comp_fault    <= 1'b0;
            end
        end
    end

    // ****************************************
    // Status word
    // ****************************************
    always @(posedge clk_sys) begin
        if (rst)
            status_word <= 16'h0000;
        else begin
            status_word <= 16'h0000;
            status_word[`CUESUP_STAT_FATAL_BIT] <= fatal_err;
            status_word[`CUESUP_STAT_NONF_BIT]  <= nonfatal_err;
            // RQ10 watchdog flag
            status_word[`CUESUP_STAT_WDT_BIT]   <= wdt_reg;
            // RQ11 RQ13 error codes
            if (alloc_reg)
                status_word[7:0] <= `CUESUP_CODE_ALLOC;
            else if (wdt_reg)
                status_word[7:0] <= `CUESUP_CODE_WDT;
            else if (hostrun_reg)
                status_word[7:0] <= `CUESUP_CODE_HOSTRUN;
            else if (host_fail_reg)
                status_word[7:0] <= `CUESUP_CODE_HOSTCOMM;
            else if (setting_reg)
                status_word[7:0] <= `CUESUP_CODE_SETTING;
        end
    end
endmodule // cuesup_top

// file: tb/cuesup_chk.sv
`timescale 1ns/100ps
// ****************************
// Error class checker
// ****************************
module cuesup_chk (
    input wire        clk_sys,                  // Clock
    input wire        rst,                      // Reset
    input wire        run_ctl,                  // Run control
    input wire        write_fail,               // Write refused
    input wire        alloc_overrun,            // Overrun
    input wire        setting_err,              // Bad setting
    input wire [15:0] setting_addr,             // Its address
    input wire [15:0] status_word,              // Status
    input wire [15:0] bad_setting_address_word, // Address word
    input wire        retry_write,              // Rewrite
    input wire        comp_fault,               // Component fault
    input wire        fatal_err,                // Fatal
    input wire        nonfatal_err,             // Non-fatal
    input wire        err_lamp                  // Lamp
);
    reg [1:0] wf_reg;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    // Refused writes since power-up
    always @(posedge clk_sys) begin
        if (rst)
            wf_reg <= 2'h0;
        else if (write_fail && wf_reg != 2'h3)
            wf_reg <= wf_reg + 2'h1;
    end
    AST_LAMP_OFF: assert property (!fatal_err && !nonfatal_err |-> !err_lamp)
        else $error("lamp lit with no error");
    AST_LAMP_FATAL: assert property (fatal_err |-> err_lamp)
        else $error("lamp not steady on fatal");
    AST_WDT_LATCH: assert property (status_word[10] |=> status_word[10])
        else $error("watchdog flag dropped");
    AST_ALLOC: assert property (alloc_overrun && !fatal_err && !nonfatal_err
        |-> ##2 status_word[7:0] == 8'h15 && status_word[8]) else $error("overrun code");
    AST_SET_ADDR: assert property (setting_err && !fatal_err
        |-> ##2 bad_setting_address_word == $past(setting_addr, 2)) else $error("bad address");
    AST_SET_HOLD: assert property (nonfatal_err && !comp_fault && !$past(comp_fault)
        && run_ctl == $past(run_ctl) && run_ctl == $past(run_ctl, 2) |=> nonfatal_err)
        else $error("setting error cleared early");
    AST_RETRY: assert property (write_fail && wf_reg < 2'h2 |-> ##[1:2] retry_write)
        else $error("no rewrite request");
    AST_THIRD: assert property (write_fail && wf_reg == 2'h2
        |-> ##2 fatal_err && status_word[7:0] == 8'h0d) else $error("third refusal not fatal");
endmodule // cuesup_chk
bind cuesup_top cuesup_chk cuesup_chk_inst (.clk_sys(clk_sys), .rst(rst), .run_ctl(run_ctl),
    .write_fail(write_fail), .alloc_overrun(alloc_overrun), .setting_err(setting_err),
    .setting_addr(setting_addr), .status_word(status_word), .retry_write(retry_write),
    .bad_setting_address_word(bad_setting_address_word), .comp_fault(comp_fault),
    .fatal_err(fatal_err), .nonfatal_err(nonfatal_err), .err_lamp(err_lamp));

// file: tb/cuesup_partner.sv
`timescale 1ns/100ps
// ****************************
// Host and component stand-in
// ****************************
module cuesup_partner (
    input  wire clk_sys,   // Clock
    input  wire rst,       // Reset
    input  wire comp_req,  // Component request
    output reg  host_ack,  // Host answer
    output reg  comp_resp  // Component answer
);
    reg [3:0] wait_reg;
    reg [1:0] lag_reg;
    initial begin
        host_ack = 1'b0;
        comp_resp = 1'b0;
        wait_reg = 4'h0;
        lag_reg = 2'h0;
    end
    // Host answers late, leaving a window before contact
    always @(posedge clk_sys) begin
        wait_reg <= rst ? 4'h0 : wait_reg + {3'h0, wait_reg != 4'hf};
        host_ack <= !rst && wait_reg == 4'hc;
        lag_reg <= comp_req ? 2'h3 : lag_reg - {1'b0, lag_reg != 2'h0};
        comp_resp <= lag_reg == 2'h1;
    end
endmodule // cuesup_partner

// file: tb/cuesup_top_tb.sv
`timescale 1ns/100ps
module cuesup_top_tb;
    localparam EV_SET = 8'h01, EV_AL = 8'h02, EV_WF = 8'h04, EV_WDT = 8'h08;
    localparam EV_HC = 8'h10, EV_CE = 8'h20, EV_CR = 8'h40, EV_SC = 8'h80;
    reg         clk_sys, rst, run_ctl;
    reg  [7:0]  ev, comp_err_code;
    reg  [3:0]  cfg_timeout;
    reg  [15:0] cmd_bits, setting_addr;
    reg  [4:0]  comp_index;
    wire        host_ack, comp_resp, retry_write, mon_we, host_ready, comp_fault;
    wire        fatal_err, nonfatal_err, err_lamp;
    wire [15:0] status_word, bad_setting_address_word, active_cmd_bits;
    wire [3:0]  active_timeout;
    wire [4:0]  mon_index;
    wire [7:0]  mon_code;
    integer     num_errors, num_checks, i;
    cuesup_top cuesup_top_inst (.clk_sys(clk_sys), .rst(rst), .scan_tick(ev[7]),
        .run_ctl(run_ctl), .cfg_timeout(cfg_timeout), .cmd_bits(cmd_bits), .host_ack(host_ack),
        .host_comm_err(ev[4]), .write_fail(ev[2]), .wdt_expired(ev[3]), .alloc_overrun(ev[1]),
        .setting_err(ev[0]), .setting_addr(setting_addr), .comp_req(ev[6]), .comp_resp(comp_resp),
        .comp_err(ev[5]), .comp_index(comp_index), .comp_err_code(comp_err_code),
        .status_word(status_word), .bad_setting_address_word(bad_setting_address_word),
        .active_cmd_bits(active_cmd_bits), .active_timeout(active_timeout),
        .retry_write(retry_write), .mon_we(mon_we), .mon_index(mon_index), .mon_code(mon_code),
        .host_ready(host_ready), .comp_fault(comp_fault), .fatal_err(fatal_err),
        .nonfatal_err(nonfatal_err), .err_lamp(err_lamp));
    cuesup_partner cuesup_partner_inst (.clk_sys(clk_sys), .rst(rst), .comp_req(ev[6]),
        .host_ack(host_ack), .comp_resp(comp_resp));
    task chk(input [15:0] seen, input [15:0] exp);
        begin
            num_checks = num_checks + 1;
            if (seen !== exp) begin
                num_errors = num_errors + 1;
                $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
            end
        end
    endtask
    task cyc(input integer n);
        repeat (n) @(negedge clk_sys);
    endtask
    // Single-cycle event, then let latch and status settle
    task fire(input [7:0] m);
        begin
            @(negedge clk_sys) ev = m;
            @(negedge clk_sys) ev = 8'h00;
            cyc(2);
        end
    endtask
    task restart;
        begin
            @(negedge clk_sys) run_ctl = 1'b0;
            cyc(2);
            run_ctl = 1'b1;
            cyc(3);
        end
    endtask
    task do_reset;
        begin
            @(negedge clk_sys) rst = 1'b1;
            run_ctl = 1'b0;
            cyc(10);
            rst = 1'b0;
        end
    endtask
    task t_idle;
        begin
            chk(err_lamp, 0);
            chk(status_word, 16'h0000);
            fire(EV_HC);
            chk(fatal_err, 0);
            cyc(15);
            chk(host_ready, 1);
        end
    endtask
    task t_cfg;
        begin
            @(negedge clk_sys) cfg_timeout = 4'h7;
            cmd_bits = 16'h4300;
            run_ctl = 1'b1;
            fire(EV_SC);
            chk(active_timeout, 4'h7);
            chk(active_cmd_bits, 16'h4300);
            // Write bit dropped after one scan to spare wear
            cfg_timeout = 4'h3;
            cmd_bits = 16'h0400;
            fire(EV_SC);
            chk(active_cmd_bits, 16'h0400);
            chk(active_timeout, 4'h7);
        end
    endtask
    task t_setting;
        begin
            setting_addr = 16'h0123;
            fire(EV_SET);
            chk(status_word, 16'h0202);
            chk(bad_setting_address_word, 16'h0123);
            chk(fatal_err, 0);
            @(negedge clk_sys) run_ctl = 1'b0;
            cyc(20);
            chk(nonfatal_err, 1);
            restart;
            chk(nonfatal_err, 0);
        end
    endtask
    task t_comp;
        begin
            comp_index = 5'h09;
            comp_err_code = 8'h42;
            @(negedge clk_sys) ev = EV_CE;
            @(negedge clk_sys) ev = 8'h00;
            chk(mon_we, 1);
            @(negedge clk_sys) chk(mon_we, 0);
            cyc(1);
            chk({mon_index, mon_code}, 16'h0942);
            chk({comp_fault, nonfatal_err, fatal_err}, 3'h6);
            fire(EV_CR);
            cyc(6);
            chk({comp_fault, nonfatal_err}, 2'h0);
        end
    endtask
    task t_fatal;
        begin
            fire(EV_AL);
            chk(status_word, 16'h0115);
            cyc(5);
            chk(err_lamp, 1);
            restart;
            chk(fatal_err, 0);
            for (i = 0; i < 3; i = i + 1) begin
                fire(EV_WF);
                chk(fatal_err, i == 2);
            end
            chk(status_word, 16'h010d);
            restart;
            chk(fatal_err, 1);
            do_reset;
            cyc(16);
            fire(EV_HC);
            chk(status_word, 16'h010c);
            do_reset;
            fire(EV_WDT);
            chk(status_word, 16'h050e);
            restart;
            chk(status_word[10], 1);
        end
    endtask
    task end_sim;
        begin
            $display("checks %0d errors %0d", num_checks, num_errors);
            if (num_errors == 0 && num_checks > 0)
                $display("TEST PASSED");
            else
                $display("TEST FAILED");
            $finish;
        end
    endtask
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end
    initial begin
        #(100 * 3000);
        num_errors = num_errors + 1;
        end_sim;
    end
    initial begin
        {rst, run_ctl, ev, cfg_timeout, cmd_bits, setting_addr} = {1'b1, 45'h0};
        {comp_index, comp_err_code, num_errors, num_checks} = 0;
        do_reset;
        t_idle;
        t_cfg;
        t_setting;
        t_comp;
        t_fatal;
        end_sim;
    end
endmodule // cuesup_top_tb
